// ---- rtl/fuse_loader.sv ----
`timescale 1ns/1ps
`default_nettype none
module fuse_loader #(
  parameter int WORDS = init_seq_pkg::FUSE_WORDS
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_start,
  output logic      o_done
);
  import init_seq_pkg::*;

  logic [3:0] idx_q, idx_d;
  logic       busy_q, busy_d, done_q, done_d;

  always_comb begin
    idx_d  = idx_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (i_start) begin
      idx_d  = 4'h0;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (idx_q == 4'(WORDS - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        idx_d = idx_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_q  <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      idx_q  <= idx_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;
endmodule
`default_nettype wire

// ---- rtl/init_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module init_seq #(
  parameter int CAL_LEN = init_seq_pkg::CAL_CYCLES
) (
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RST_N,
  input  wire logic       I_RESET_PIN,
  input  wire logic       I_REFERENCE_BUFFER_SELECT_PIN,
  input  wire logic       I_REG_WR,
  input  wire logic [7:0] I_REG_ADDR,
  input  wire logic [7:0] I_REG_WDATA,
  output logic      [7:0] O_REG_RDATA,
  output logic            O_READY,
  output logic            O_CAL_BUSY,
  output logic            O_REF_SEL
);
  import init_seq_pkg::*;

  // pins come from the host's domain
  logic rst_s1_q, rst_s2_q, rst_prev_q, ref_s1_q, ref_s2_q;
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_s1_q   <= 1'b0;
      rst_s2_q   <= 1'b0;
      rst_prev_q <= 1'b0;
      ref_s1_q   <= 1'b0;
      ref_s2_q   <= 1'b0;
    end else begin
      rst_s1_q   <= I_RESET_PIN;
      rst_s2_q   <= rst_s1_q;
      rst_prev_q <= rst_s2_q;
      ref_s1_q   <= I_REFERENCE_BUFFER_SELECT_PIN;
      ref_s2_q   <= ref_s1_q;
    end
  end

  // one decode serves the write strobe and the read mux
  function automatic logic addr_is_ctrl(input logic [7:0] a);
    return (a == SW_RESET_CTRL_ADDR);
  endfunction

  logic hw_release;
  logic sw_hit;
  assign hw_release = rst_prev_q & ~rst_s2_q;
  assign sw_hit = I_REG_WR && addr_is_ctrl(I_REG_ADDR) && I_REG_WDATA[SW_RESET_BIT];

  init_state_t       st_q, st_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [7:0]        ctrl_q, ctrl_d;
  logic              ref_q, ref_d;
  logic              load_start;
  logic              load_done;
  logic              ready_q, ready_d;
  logic              busy_q, busy_d;

  fuse_loader #(
    .WORDS (FUSE_WORDS)
  ) u_fuse (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_start (load_start),
    .o_done  (load_done)
  );

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    ctrl_d     = ctrl_q;
    ref_d      = ref_q;
    load_start = 1'b0;
    if (rst_s2_q) begin
      // held in reset: state, count and control sit at defaults, ref_q keeps its latched level
      st_d   = ST_IDLE;
      ctrl_d = SW_RESET_CTRL_RST;
      cnt_d  = '0;
    end else if (hw_release || sw_hit) begin
      // both reset sources restart the same load and calibration
      st_d       = ST_LOAD;
      load_start = 1'b1;
      cnt_d      = '0;
      ctrl_d     = SW_RESET_CTRL_RST;
      ctrl_d[SW_RESET_BIT] = sw_hit;
      ref_d      = ref_s2_q;
    end else begin
      case (st_q)
        ST_IDLE: st_d = ST_IDLE;
        ST_LOAD: begin
          ctrl_d = SW_RESET_CTRL_RST;
          if (load_done) begin
            st_d = ST_CAL;
          end
        end
        ST_CAL: begin
          if (cnt_q == CNT_W'(CAL_LEN - 1)) begin
            st_d = ST_READY;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        ST_READY: st_d = ST_READY;
        default:  st_d = ST_IDLE;
      endcase
    end
    // outputs are registered from the next state so they line up with st_q
    ready_d = (st_d == ST_READY);
    busy_d  = (st_d == ST_LOAD) || (st_d == ST_CAL);
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q    <= ST_IDLE;
      cnt_q   <= '0;
      ctrl_q  <= SW_RESET_CTRL_RST;
      ref_q   <= 1'b0;
      ready_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      ctrl_q  <= ctrl_d;
      ref_q   <= ref_d;
      ready_q <= ready_d;
      busy_q  <= busy_d;
    end
  end

  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    if (addr_is_ctrl(I_REG_ADDR)) begin
      rdata_d = ctrl_q;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign O_REG_RDATA = rdata_q;
  assign O_READY     = ready_q;
  assign O_CAL_BUSY  = busy_q;
  assign O_REF_SEL   = ref_q;

  // checker-side run length, counted apart from cnt_q so a broken terminal compare shows up
  logic [CNT_W-1:0] cal_run_q, cal_run_d;
  always_comb begin
    cal_run_d = '0;
    if (st_q == ST_CAL) begin
      cal_run_d = cal_run_q + 1'b1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cal_run_q <= '0;
    end else begin
      cal_run_q <= cal_run_d;
    end
  end

  sequence s_fuse_then_cal;
    (st_q == ST_LOAD) ##[1:20] (st_q == ST_CAL);
  endsequence

  sequence s_bit_pulse;
    ctrl_q[SW_RESET_BIT] ##1 !ctrl_q[SW_RESET_BIT];
  endsequence

  // a restart or a reset pulse may cut calibration short, so only an undisturbed run is held to length
  a_cal_length : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_q == ST_CAL && st_d == ST_READY) |-> (cal_run_q == CNT_W'(CAL_LEN - 1)))
    else $error("calibration length wrong");

  a_cal_holds : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_q == ST_CAL && cal_run_q != CNT_W'(CAL_LEN - 1) && !sw_hit && !rst_s2_q) |=> (st_q == ST_CAL))
    else $error("calibration ended early");

  a_swbit_clears : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_q == ST_LOAD && !sw_hit && !rst_s2_q) |=> !ctrl_q[SW_RESET_BIT])
    else $error("reset bit stuck");

  a_sw_starts : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (sw_hit && !rst_s2_q) |=> (st_q == ST_LOAD) && ctrl_q[SW_RESET_BIT])
    else $error("soft reset ignored");

  a_bit_pulse : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (sw_hit && !rst_s2_q) ##1 (!sw_hit && !rst_s2_q) |-> s_bit_pulse)
    else $error("reset bit not a single pulse");

  a_hw_release : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    hw_release |=> s_fuse_then_cal)
    else $error("no load after release");

  a_sw_to_cal : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (sw_hit && !rst_s2_q) |=> s_fuse_then_cal)
    else $error("no load after soft reset");

  a_reset_hold : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    rst_s2_q |=> (st_q == ST_IDLE) && (ctrl_q == SW_RESET_CTRL_RST))
    else $error("state ran in reset");

  a_ready_stays : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (O_READY && !sw_hit && !rst_s2_q) |=> O_READY)
    else $error("ready dropped without reset");

  a_ready_late : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $rose(O_READY) |-> ($past(st_q) == ST_CAL) && ($past(cal_run_q) == CNT_W'(CAL_LEN - 1)))
    else $error("ready before calibration done");

  a_ref_latch : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    hw_release |=> (O_REF_SEL == $past(ref_s2_q)))
    else $error("select level not latched");

  a_rdata_ctrl : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    addr_is_ctrl(I_REG_ADDR) |=> (O_REG_RDATA == $past(ctrl_q)))
    else $error("control readback wrong");

  a_rdata_other : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !addr_is_ctrl(I_REG_ADDR) |=> (O_REG_RDATA == 8'h00))
    else $error("unmapped readback not zero");

  a_idle_quiet : assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (st_q == ST_IDLE) |-> !O_CAL_BUSY && !O_READY)
    else $error("outputs active while idle");
endmodule
`default_nettype wire

// ---- rtl/init_seq_pkg.sv ----
`default_nettype none
package init_seq_pkg;
  localparam logic [7:0]  SW_RESET_CTRL_ADDR = 8'h00;
  localparam int          SW_RESET_BIT       = 0;
  localparam logic [7:0]  SW_RESET_CTRL_RST  = 8'h00;
  localparam int          CAL_CYCLES         = 200000;
  localparam int          FUSE_WORDS         = 4;
  localparam int          CNT_W              = 18;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_CAL   = 2'b10,
    ST_READY = 2'b11
  } init_state_t;
endpackage
`default_nettype wire

// ---- test/adc_powerup_reset_init_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_powerup_reset_init_tb_top;
  import init_seq_pkg::*;
  localparam int CAL = 20;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  wire logic       rpin, sel, wr, rdy, busy, rsel;
  wire logic [7:0] addr, wdata, rdata;
  int              fail_count = 0;
  int              comparisons = 0;
  int              cyc = 0;
  int              n;
  always #2.5 clk = ~clk;
  host_model i_host (.i_clk(clk), .o_rst_pin(rpin), .o_sel(sel), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  init_seq #(.CAL_LEN(CAL)) i_dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_RESET_PIN(rpin),
    .I_REFERENCE_BUFFER_SELECT_PIN(sel), .I_REG_WR(wr), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_READY(rdy), .O_CAL_BUSY(busy), .O_REF_SEL(rsel));
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // loose window: pin synchroniser and state hops add a few cycles
  function automatic logic [7:0] in_time(input int c);
    return {7'h00, c >= CAL && c <= FUSE_WORDS + CAL + 8};
  endfunction
  task automatic wait_ready();
    n = 0;
    while (rdy !== 1'b1 && n < 200) begin
      @(posedge clk) #1 n++;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    void'($urandom(66215));
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int s = 0; s < 2; s++) begin
      i_host.hw_reset(s[0]);
      repeat (6) @(posedge clk);
      #1 check({6'h00, busy, rdy}, 8'h02);
      wait_ready();
      check(in_time(n + 6), 8'h01);
      check({6'h00, busy, rsel}, {7'h00, s[0]});
    end
    repeat (8) begin
      i_host.write(8'($urandom_range(255, 1)), 8'($urandom));
      i_host.write(SW_RESET_CTRL_ADDR, 8'($urandom) & 8'hfe);
      @(posedge clk) #1 check({6'h00, busy, rdy}, 8'h01);
    end
    for (int k = 0; k < 2; k++) begin
      i_host.write(SW_RESET_CTRL_ADDR, 8'($urandom) | 8'h01);
      if (k == 1) i_host.write(SW_RESET_CTRL_ADDR, 8'h01);
      @(posedge clk) #1 check({6'h00, busy, rdy}, 8'h02);
      check(rdata, 8'(1 << SW_RESET_BIT));
      repeat (3) @(posedge clk);
      #1 check(rdata, SW_RESET_CTRL_RST);
      wait_ready();
      check(in_time(n + 4), 8'h01);
    end
    summarize();
  end
endmodule
`default_nettype wire

// ---- test/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       i_clk,
  output logic            o_rst_pin,
  output logic            o_sel,
  output logic            o_wr,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_rst_pin = 1'b0;
    o_sel = 1'b0;
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // clock runs from time zero; select settles before the pulse
  task automatic hw_reset(input logic s);
    @(posedge i_clk) #1 o_sel = s;
    repeat (3) @(posedge i_clk);
    #1 o_rst_pin = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 o_rst_pin = 1'b0;
  endtask
  // data flips once the strobe drops so stale data never matches
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1 o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk) #1 o_wr = 1'b0;
    o_wdata = ~d;
  endtask
endmodule
`default_nettype wire
